// File: shared/flash_access_protection_defines.vh
// Constants for the flash access protection block.
// Assumes inclusion by bare name from the design files.
`ifndef FLASH_ACCESS_PROTECTION_DEFINES_VH
`define FLASH_ACCESS_PROTECTION_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_INFO_INDEX   16'hF880
`define IDX_INFO_DATA    16'hF882
`define IDX_WRITE_GUARD  16'hF890
`define IDX_EVENT_STAT   16'hF8A0
`define IDX_EVENT_MASK   16'hF8A2
`define IDX_HOST_LIMIT   16'hF8A4
`define IDX_PROT_WORD    16'hF8A6

// Reset values
`define RST_WRITE_GUARD  16'h0000
`define RST_PROT_WORD    16'h0000
`define RST_HOST_LIMIT   16'hFFFF

// Protection word fields
`define PW_BOOT_MSB      3
`define PW_BOOT_LSB      0
`define PW_HOST_BOOT     4
`define PW_CP_MSB        9
`define PW_CP_LSB        7

// Core boot size codes and their 8 Kbyte region counts
`define BOOT_56K         4'h7
`define BOOT_80K         4'h6
`define BOOT_96K         4'h5
`define BOOT_112K        4'h4
`define BOOT_128K        4'h3
`define REG_56K          5'h07
`define REG_80K          5'h0A
`define REG_96K          5'h0C
`define REG_112K         5'h0E
`define REG_128K         5'h10
`define HOST_BOOT_FIRST  5'h08

// Information block layout
`define INFO_FACT_LAST   8'h7F
`define INFO_PW_LO       8'hFE

// Initiators
`define SRC_CORE         2'h0
`define SRC_HOST         2'h1
`define SRC_DEBUG        2'h2
`define SRC_PAR          2'h3

// Operations
`define OP_READ          2'h0
`define OP_PROG          2'h1
`define OP_ERASE         2'h2
`define OP_SPECIAL       2'h3

// Event status bits
`define EV_CORE          0
`define EV_HOST          1
`define EV_PORT          2
`define EV_INFO          3

`endif

// File: verilog/flash_access_protection.v
// Flash access protection: judges every flash access by initiator,
// holds the core write guard and the indirect information block port.
// Assumes an APB master on pclk and a flash controller that loads
// the protection word at internal reset and acks information reads.
// Assumes the controller obeys chk_deny and hold_reset; no
// program or erase timing lives here.
`timescale 1ns/1ps
`default_nettype none
`include "flash_access_protection_defines.vh"

module flash_access_protection #(
    parameter AW = 18  // APB address width
) (
    // Clock, reset, enable
    input  wire          pclk,
    input  wire          presetn,
    input  wire          clk_en,

    // APB slave
    // Setup, then access; pready ends it
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [AW-1:0] paddr,
    input  wire [31:0]   pwdata,
    input  wire [3:0]    pstrb,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,

    // Access check port
    // One request a cycle, verdict next cycle
    input  wire          req_valid,
    input  wire [1:0]    req_src,
    input  wire [1:0]    req_op,
    input  wire          req_info,
    input  wire [16:0]   req_addr,
    output reg           chk_grant,
    output reg           chk_deny,

    // Protection word load and environment
    // Word loads during internal reset
    input  wire          pword_load,
    input  wire [15:0]   pword_in,
    input  wire          debug_env,
    input  wire          special_done,
    input  wire [15:0]   host_word_limit,
    output reg           hold_reset,

    // Information block port
    // Single-cycle strobes, reads wait for ack
    output reg           ib_rd,
    output reg           ib_wr,
    output reg           ib_word,
    output reg  [7:0]    ib_addr,
    output reg  [15:0]   ib_wdata,
    input  wire          ib_ack,
    input  wire [15:0]   ib_rdata,

    // Interrupt
    // Level, high while an enabled event waits
    output reg           irq
);

    // Register storage
    // All state freezes while clk_en is low
    // Only the index byte is stored
    reg  [7:0]  index_q;       // Information block byte address
    reg  [15:0] guard_q;       // Core write guard
    reg  [15:0] pword_q;       // Protection word
    reg  [15:0] hlimit_q;      // Core-set host restriction
    reg  [3:0]  stat_q;        // Sticky events
    reg  [3:0]  mask_q;        // Event enables
    reg         wait_q;        // Information read outstanding

    // Bus decode
    // Taken once per access phase; a raised
    // pready or a waiting read blocks a retake
    wire        acc     = psel & penable & ~pready & ~wait_q;
    // Write and read effects act only when taken
    wire        wr      = acc & pwrite;
    wire        rd      = acc & ~pwrite;

    // Byte address is four times the index
    wire        hit_idx = paddr == {`IDX_INFO_INDEX, 2'b00};
    wire        hit_dat = paddr == {`IDX_INFO_DATA, 2'b00};
    wire        hit_grd = paddr == {`IDX_WRITE_GUARD, 2'b00};
    wire        hit_st  = paddr == {`IDX_EVENT_STAT, 2'b00};
    wire        hit_msk = paddr == {`IDX_EVENT_MASK, 2'b00};
    wire        hit_hl  = paddr == {`IDX_HOST_LIMIT, 2'b00};
    wire        hit_pw  = paddr == {`IDX_PROT_WORD, 2'b00};
    // Unmapped addresses answer with an error
    wire        hit_any = hit_idx | hit_dat | hit_grd | hit_st |
                          hit_msk | hit_hl | hit_pw;

    // Content protect open only with all three bits set
    // Stored copy judges, raw input sets the hold
    wire        cp_open = &pword_q[`PW_CP_MSB:`PW_CP_LSB];
    wire        cp_in   = &pword_in[`PW_CP_MSB:`PW_CP_LSB];

    // Core boot region count decoded from the protection word
    // Regions counted up from region 0
    reg  [4:0]  boot_n;
    always @* begin
        // Five codes name a core boot size
        case (pword_q[`PW_BOOT_MSB:`PW_BOOT_LSB])
            `BOOT_56K:  boot_n = `REG_56K;
            `BOOT_80K:  boot_n = `REG_80K;
            `BOOT_96K:  boot_n = `REG_96K;
            `BOOT_112K: boot_n = `REG_112K;
            `BOOT_128K: boot_n = `REG_128K;
            // Reserved codes give no core boot area
            default:    boot_n = 5'h00;
        endcase
    end

    // Per-region boot membership: core boot low, host boot top 64K
    // Either area alone makes a region read only to the core
    // One membership bit per 8 Kbyte region
    wire [15:0] boot_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_boot
            // Core area from below, host area from 8 up
            assign boot_mask[gi] = (gi < boot_n) |
                (~pword_q[`PW_HOST_BOOT] & (gi >= `HOST_BOOT_FIRST));
        end
    endgenerate

    // Region of the checked address, 8 Kbyte each
    // Anything but a read changes flash
    // Factory page at the bottom, word at the top
    wire [3:0]  region   = req_addr[16:13];
    wire        req_wr   = req_op != `OP_READ;
    wire        in_fact  = req_addr[7:0] <= `INFO_FACT_LAST;
    wire        in_pw    = req_addr[7:0] >= `INFO_PW_LO;

    // Access verdict per initiator
    // Registered below: stands one cycle later
    reg         allow;
    always @* begin
        // Refused unless a branch grants
        allow = 1'b0;
        // Unknown initiators fall to default
        case (req_src)
            `SRC_CORE: begin
                // Reads free; writes walk info, boot, guard
                if (req_op == `OP_READ)
                    allow = 1'b1;
                else if (req_op == `OP_SPECIAL)
                    allow = 1'b0;
                else if (req_info)
                    allow = ~(in_fact | in_pw);
                else if (boot_mask[region])
                    allow = 1'b0;
                else
                    allow = guard_q[region];
            end
            `SRC_HOST: begin
                // Main block only, within both limits
                // Word limits and core limits both must allow
                if (req_info || req_op == `OP_SPECIAL)
                    allow = 1'b0;
                else
                    allow = host_word_limit[region] &
                            hlimit_q[region];
            end
            `SRC_DEBUG: begin
                // Special erase is the way out
                if (req_op == `OP_SPECIAL)
                    allow = cp_open | debug_env;
                else if (!cp_open)
                    allow = 1'b0;
                else
                    allow = ~(req_info & in_fact & req_wr);
            end
            `SRC_PAR: begin
                // Debug scheme without the environment
                if (req_op == `OP_SPECIAL)
                    allow = 1'b1;
                else if (!cp_open)
                    allow = 1'b0;
                else
                    allow = ~(req_info & in_fact & req_wr);
            end
            default: allow = 1'b0;
        endcase
    end

    // Indirect data access shape and protection
    // Reads size from index parity, writes
    // from the low byte strobes
    wire        dat_word = pwrite ? (pstrb[1:0] == 2'b11) : ~index_q[0];
    wire        mis_word = dat_word & index_q[0];
    wire        ib_block = (index_q <= `INFO_FACT_LAST) |
                           (index_q >= `INFO_PW_LO);
    // A write needs a low byte strobe
    wire        dat_nostb = pwrite & (pstrb[1:0] == 2'b00);
    wire        dat_bad   = hit_dat & (mis_word | dat_nostb);
    // Legal write to a locked offset: dropped
    wire        dat_wdrop = wr & hit_dat & ~dat_bad & ib_block;

    // Events from checks and dropped indirect writes
    // Every refused check is an event, reads too
    wire        deny_now = req_valid & ~allow;
    wire [3:0]  ev;
    assign ev[`EV_CORE] = deny_now & (req_src == `SRC_CORE);
    assign ev[`EV_HOST] = deny_now & (req_src == `SRC_HOST);
    // Debug and parallel refusals share a bit
    assign ev[`EV_PORT] = deny_now & req_src[1];
    assign ev[`EV_INFO] = dat_wdrop;
    // Write one clears; a same-cycle event wins
    wire [3:0]  st_clr  = (wr & hit_st) ? pwdata[3:0] : 4'h0;
    wire [3:0]  st_d    = (stat_q & ~st_clr) | ev;

    // Read mux for plain registers
    // The data register answers in the transfer process
    reg  [15:0] rmux;
    always @* begin
        // Default keeps the mux free of latches
        rmux = 16'h0000;
        if (hit_idx)
            rmux = {8'h00, index_q};
        else if (hit_grd)
            rmux = guard_q;
        else if (hit_st)
            rmux = {12'h000, stat_q};
        else if (hit_msk)
            rmux = {12'h000, mask_q};
        else if (hit_hl)
            rmux = hlimit_q;
        else if (hit_pw)
            rmux = pword_q;
        else
            rmux = 16'h0000;
    end

    // Register writes, protection word, events, reset hold
    // Nothing moves while clk_en is low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Guard closed until software opens it
            index_q    <= 8'h00;
            guard_q    <= `RST_WRITE_GUARD;
            pword_q    <= `RST_PROT_WORD;
            hlimit_q   <= `RST_HOST_LIMIT;
            // Events clear and masked
            stat_q     <= 4'h0;
            mask_q     <= 4'h0;
            // No hold and no interrupt out of reset
            hold_reset <= 1'b0;
            irq        <= 1'b0;
            // No verdict stands
            chk_grant  <= 1'b0;
            chk_deny   <= 1'b0;
        end else if (clk_en) begin
            // Software writes land at the access edge
            // Only the index byte is kept
            if (wr & hit_idx)
                index_q <= pwdata[7:0];
            // Guard change applies to the next check
            if (wr & hit_grd)
                guard_q <= pwdata[15:0];
            // Mask matches the status layout
            if (wr & hit_msk)
                mask_q <= pwdata[3:0];
            // ANDed with the word's own host limit
            // Core may only narrow host reach
            if (wr & hit_hl)
                hlimit_q <= pwdata[15:0];
            // Word taken at internal reset sequence
            if (pword_load)
                pword_q <= pword_in;
            // Hold until special erase finishes; load wins
            // Only a protected load in debug raises it
            if (pword_load)
                hold_reset <= ~cp_in & debug_env;
            else if (special_done)
                hold_reset <= 1'b0;
            // Status, irq and verdicts are registered
            // Set beats clear
            stat_q    <= st_d;
            irq       <= |(st_d & mask_q);
            chk_grant <= req_valid & allow;
            chk_deny  <= deny_now;
        end
    end

    // APB answers and indirect information block transfers
    // pready stands one cycle; pslverr holds until the next answer, prdata until the next read or non-data answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Bus quiet
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            // No read outstanding, port idle
            wait_q   <= 1'b0;
            ib_rd    <= 1'b0;
            ib_wr    <= 1'b0;
            ib_word  <= 1'b0;
            ib_addr  <= 8'h00;
            ib_wdata <= 16'h0000;
        end else if (clk_en) begin
            // Strobes and pready are one-cycle pulses
            pready <= 1'b0;
            ib_rd  <= 1'b0;
            ib_wr  <= 1'b0;
            // A pending read ignores the bus
            if (wait_q) begin
                // Read answer completes the access
                // Byte reads keep only the low byte
                if (ib_ack) begin
                    wait_q  <= 1'b0;
                    pready  <= 1'b1;
                    pslverr <= 1'b0;
                    prdata  <= {16'h0000, ib_word ? ib_rdata :
                                {8'h00, ib_rdata[7:0]}};
                end
            end else if (acc) begin
                if (hit_dat & ~dat_bad) begin
                    ib_addr <= index_q;
                    ib_word <= dat_word;
                    // Size and index latched either way
                    if (pwrite) begin
                        // Dropped with no bus error when protected
                        ib_wr    <= ~ib_block;
                        ib_wdata <= (pstrb[1:0] == 2'b10) ?
                                    {8'h00, pwdata[15:8]} : pwdata[15:0];
                        pready   <= 1'b1;
                        pslverr  <= 1'b0;
                    end else begin
                        // Completes when the block acknowledges
                        ib_rd  <= 1'b1;
                        wait_q <= 1'b1;
                    end
                end else begin
                    // Unmapped or misaligned: error answer
                    // Plain registers answer after one wait
                    pready  <= 1'b1;
                    pslverr <= ~hit_any | dat_bad;
                    // Writes return zero read data
                    prdata  <= rd ? {16'h0000, rmux} : 32'h00000000;
                end
            end
        end
    end

endmodule

`default_nettype wire

// File: verification/fap_chk.sv
// Checker for the access verdicts, hold and info port.
// Assumes one clock domain; bound to the design top.
`timescale 1ns/1ps
`default_nettype none
`include "flash_access_protection_defines.vh"
module fap_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    // Access check port
    input wire logic        req_valid,
    input wire logic [1:0]  req_src,
    input wire logic [1:0]  req_op,
    input wire logic        req_info,
    input wire logic [16:0] req_addr,
    input wire logic        chk_grant,
    input wire logic        chk_deny,
    // Protection word and hold
    input wire logic        pword_load,
    input wire logic [15:0] pword_in,
    input wire logic        debug_env,
    input wire logic        hold_reset,
    // Information block port
    input wire logic        ib_rd,
    input wire logic        ib_wr,
    input wire logic        ib_word,
    input wire logic [7:0]  ib_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] cp_q;  // Content protect field last loaded
    logic       go;    // Request taken at this edge
    assign go = req_valid && clk_en;
    // Follow the loaded protect field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cp_q <= 3'h0;
        else if (pword_load && clk_en)
            cp_q <= pword_in[9:7];
    end
    a_core_read_ok: assert property (go && req_src == `SRC_CORE && req_op == `OP_READ |=> chk_grant)
        else $error("core read refused");
    a_core_spec_no: assert property (go && req_src == `SRC_CORE && req_op == `OP_SPECIAL |=> chk_deny)
        else $error("core special erase let through");
    a_factory_locked: assert property (go && req_src == `SRC_CORE && req_info && req_op != `OP_READ
        && req_op != `OP_SPECIAL && req_addr[7:0] <= 8'h7F |=> chk_deny) else $error("factory area written");
    a_host_info_no: assert property (go && req_src == `SRC_HOST && req_info |=> chk_deny)
        else $error("host reached info block");
    a_debug_closed: assert property (go && req_src == `SRC_DEBUG && req_op != `OP_SPECIAL && cp_q != 3'h7
        |=> chk_deny) else $error("debug access while protected");
    a_par_special: assert property (go && req_src == `SRC_PAR && req_op == `OP_SPECIAL |=> chk_grant)
        else $error("parallel special erase refused");
    a_hold_raise: assert property (pword_load && clk_en && pword_in[9:7] != 3'h7 && debug_env |=> hold_reset)
        else $error("hold not raised");
    a_verdict_cause: assert property (chk_grant || chk_deny |-> !(chk_grant && chk_deny) && $past(go))
        else $error("verdict without request");
    a_drop_factory: assert property (ib_wr |-> ib_addr > 8'h7F && ib_addr < 8'hFE)
        else $error("protected info byte written");
    a_word_align: assert property ((ib_rd || ib_wr) && ib_word |-> !ib_addr[0])
        else $error("odd word access");
    c_debug_grant: cover property (go && req_src == `SRC_DEBUG ##1 chk_grant);
    c_info_read: cover property (ib_rd);
    c_hold: cover property (hold_reset);
endmodule
bind flash_access_protection fap_chk u_fap_chk (.pclk, .presetn, .clk_en, .req_valid, .req_src, .req_op,
    .req_info, .req_addr, .chk_grant, .chk_deny, .pword_load, .pword_in, .debug_env, .hold_reset,
    .ib_rd, .ib_wr, .ib_word, .ib_addr);
`default_nettype wire

// File: verification/fap_info_mem.sv
// Information block model behind the indirect port.
// Assumes single-cycle ib_rd/ib_wr pulses on pclk.
`timescale 1ns/1ps
`default_nettype none
module fap_info_mem #(
    parameter LAT = 3  // Read answer delay in cycles
) (
    // Clock
    input  wire logic        pclk,
    // Port from the design
    input  wire logic        ib_rd,
    input  wire logic        ib_wr,
    input  wire logic        ib_word,
    input  wire logic [7:0]  ib_addr,
    input  wire logic [15:0] ib_wdata,
    output var  logic        ib_ack,
    output var  logic [15:0] ib_rdata
);
    logic [7:0] mem [0:255];  // Byte store, holds its own index
    logic [7:0] a_q;          // Address of pending read
    int         wait_q;       // Cycles left before answering
    initial begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0];
        ib_ack = 1'b0;
        ib_rdata = 16'h0000;
        wait_q = 0;
    end
    // Stores writes at once, answers reads late; data changes outside answers
    always @(posedge pclk) begin
        ib_ack <= 1'b0;
        ib_rdata <= ~ib_rdata;
        if (ib_wr) begin
            mem[ib_addr] <= ib_wdata[7:0];
            if (ib_word)
                mem[ib_addr + 8'h01] <= ib_wdata[15:8];
        end
        if (ib_rd) begin
            a_q <= ib_addr;
            wait_q <= LAT;
        end else if (wait_q > 0)
            wait_q <= wait_q - 1;
        if (wait_q == 1) begin
            ib_ack <= 1'b1;
            ib_rdata <= {mem[a_q + 8'h01], mem[a_q]};
        end
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Testbench: APB registers, access verdicts, hold and info port.
// Assumes the design, its bound checker and the info block model.
`timescale 1ns/1ps
`default_nettype none
`include "flash_access_protection_defines.vh"
module testbench;
    localparam logic [17:0] A_IDX = 18'h3E200, A_DAT = 18'h3E208, A_GRD = 18'h3E240, A_ST = 18'h3E280;
    localparam logic [17:0] A_MSK = 18'h3E288, A_HL = 18'h3E290, A_PW = 18'h3E298, A_BAD = 18'h3E2C0;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er_v;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [3:0]  pstrb;
    logic        req_valid, req_info, chk_grant, chk_deny, pword_load, debug_env, special_done;
    logic [1:0]  req_src, req_op;
    logic [16:0] req_addr;
    logic [15:0] pword_in, host_word_limit, ib_wdata, ib_rdata;
    logic        hold_reset, irq, ib_rd, ib_wr, ib_word, ib_ack;
    logic [7:0]  ib_addr;
    int          n_fail, checked, cyc;
    flash_access_protection u_flash_access_protection (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .req_valid, .req_src, .req_op, .req_info,
        .req_addr, .chk_grant, .chk_deny, .pword_load, .pword_in, .debug_env, .special_done,
        .host_word_limit, .hold_reset, .ib_rd, .ib_wr, .ib_word, .ib_addr, .ib_wdata, .ib_ack, .ib_rdata, .irq);
    fap_info_mem u_fap_info_mem (.pclk, .ib_rd, .ib_wr, .ib_word, .ib_addr, .ib_wdata, .ib_ack, .ib_rdata);
    // Counts a comparison, reports a mismatch
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; waits for pready at a rising edge
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask
    // One access check; verdict sampled in the cycle after it is taken
    task automatic chk(input logic [1:0] s, input logic [1:0] o, input logic inf, input logic [16:0] a, input logic g);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_src <= s;
        req_op <= o;
        req_info <= inf;
        req_addr <= a;
        @(posedge pclk);
        req_valid <= 1'b0;
        @(posedge pclk);
        cmp("verdict", {30'h0, g, !g}, {30'h0, chk_grant, chk_deny});
    endtask
    // Loads a protection word as the controller does at internal reset
    task automatic pw(input logic [15:0] w);
        @(posedge pclk);
        pword_load <= 1'b1;
        pword_in <= w;
        @(posedge pclk);
        pword_load <= 1'b0;
    endtask
    task automatic s_regs();
        apb(1'b0, A_GRD, 32'h0, 4'h0);
        cmp("guard", 32'h0, rd_v);
        wr(A_IDX, 32'h0000FFFF);
        apb(1'b0, A_IDX, 32'h0, 4'h0);
        cmp("index", 32'hFF, rd_v);
        apb(1'b0, A_BAD, 32'h0, 4'h0);
        cmp("unmapped", 32'h1, {31'h0, er_v});
        pw(16'h0397);
        apb(1'b0, A_PW, 32'h0, 4'h0);
        cmp("pword", 32'h0397, rd_v);
    endtask
    task automatic s_core();
        pw(16'h0000);
        for (int i = 0; i < 16; i++)
            chk(`SRC_CORE, `OP_PROG, 1'b0, {i[3:0], 13'h0}, 1'b0);
        wr(A_GRD, 32'hFFFF);
        for (int i = 0; i < 16; i++)
            chk(`SRC_CORE, `OP_ERASE, 1'b0, {i[3:0], 13'h1FFE}, i < 8);
        pw(16'h0397);
        wr(A_GRD, 32'h0180);
        for (int i = 0; i < 16; i++)
            chk(`SRC_CORE, `OP_PROG, 1'b0, {i[3:0], 13'h0}, i == 7 || i == 8);
        chk(`SRC_CORE, `OP_READ, 1'b0, 17'h0, 1'b1);
        chk(`SRC_CORE, `OP_SPECIAL, 1'b0, 17'h0, 1'b0);
        chk(`SRC_CORE, `OP_PROG, 1'b1, 17'h7F, 1'b0);
        chk(`SRC_CORE, `OP_ERASE, 1'b1, 17'hFE, 1'b0);
        chk(`SRC_CORE, `OP_PROG, 1'b1, 17'h80, 1'b1);
    endtask
    task automatic s_host();
        host_word_limit <= 16'h00F0;
        for (int i = 0; i < 16; i++)
            chk(`SRC_HOST, `OP_READ, 1'b0, {i[3:0], 13'h0}, i >= 4 && i < 8);
        wr(A_HL, 32'h0030);
        for (int i = 0; i < 16; i++)
            chk(`SRC_HOST, `OP_PROG, 1'b0, {i[3:0], 13'h0}, i == 4 || i == 5);
        chk(`SRC_HOST, `OP_READ, 1'b1, 17'h80, 1'b0);
    endtask
    task automatic s_debug();
        for (int c = 0; c < 8; c++) begin
            pw({6'h0, c[2:0], 7'h10});
            chk(`SRC_DEBUG, `OP_READ, 1'b0, 17'h0, c == 7);
            chk(`SRC_PAR, `OP_PROG, 1'b0, 17'h2000, c == 7);
            chk(`SRC_PAR, `OP_SPECIAL, 1'b0, 17'h0, 1'b1);
        end
        chk(`SRC_DEBUG, `OP_PROG, 1'b1, 17'h7F, 1'b0);
        chk(`SRC_DEBUG, `OP_ERASE, 1'b1, 17'hFE, 1'b1);
        debug_env <= 1'b1;
        pw(16'h0000);
        @(posedge pclk);
        cmp("hold", 32'h1, {31'h0, hold_reset});
        chk(`SRC_DEBUG, `OP_SPECIAL, 1'b0, 17'h0, 1'b1);
        chk(`SRC_DEBUG, `OP_READ, 1'b0, 17'h0, 1'b0);
        special_done <= 1'b1;
        @(posedge pclk);
        special_done <= 1'b0;
        debug_env <= 1'b0;
        @(posedge pclk);
        cmp("hold", 32'h0, {31'h0, hold_reset});
    endtask
    task automatic s_info();
        cmp("irq masked", 32'h0, {31'h0, irq});
        wr(A_IDX, 32'h80);
        wr(A_DAT, 32'h1234);
        apb(1'b0, A_DAT, 32'h0, 4'h0);
        cmp("info word", 32'h1234, rd_v);
        wr(A_IDX, 32'h81);
        wr(A_DAT, 32'h5678);
        cmp("odd word", 32'h1, {31'h0, er_v});
        apb(1'b0, A_DAT, 32'h0, 4'h0);
        cmp("info byte", 32'h12, rd_v);
        wr(A_MSK, 32'h8);
        wr(A_IDX, 32'h10);
        wr(A_DAT, 32'hBEEF);
        @(posedge pclk);
        cmp("irq", 32'h1, {31'h0, irq});
        apb(1'b0, A_ST, 32'h0, 4'h0);
        cmp("status", 32'hF, rd_v);
        wr(A_ST, 32'h8);
        @(posedge pclk);
        cmp("irq", 32'h0, {31'h0, irq});
        apb(1'b0, A_DAT, 32'h0, 4'h0);
        cmp("kept", 32'h1110, rd_v);
    endtask
    // Prints counts and verdict, ends the run
    task automatic conclude();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Clock of 8 ns
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Cuts a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, pstrb, paddr, pwdata} = '0;
        {req_valid, req_src, req_op, req_info, req_addr, pword_load, pword_in, debug_env, special_done} = '0;
        clk_en = 1'b1;
        host_word_limit = 16'hFFFF;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_core();
        s_host();
        s_debug();
        s_info();
        conclude();
    end
endmodule
`default_nettype wire
